// >>> pkg/mmd_pkg.sv
`default_nettype none
package mmd_pkg;

    // clock rate and the timing figures, each in nanoseconds
    localparam int CLK_PERIOD_NS      = 100;
    localparam int ROW_TO_MUX_NS      = 50;  // row hold before the mux flips
    localparam int MUX_TO_COL_NS      = 50;  // column setup before its strobe
    localparam int PRECHARGE_NS       = 120; // dram precharge, least time
    localparam int FETCH_REQ_NS       = 110; // fast fetch request high time
    localparam int FETCH_ACTIVE_NS    = 300; // longest active fetch request

    localparam int ADDR_W             = 16;
    localparam int DRAM_ADDR_W        = 8;
    localparam int CNT_W              = 4;

    // map mode codes carried on the two select bits
    localparam logic [1:0] MAP_MODE0  = 2'h0;
    localparam logic [1:0] MAP_MODE1  = 2'h1;
    localparam logic [1:0] MAP_MODE2  = 2'h2;
    localparam logic [1:0] MAP_MODE3  = 2'h3;

    // region bounds, inclusive upper ends except PRN_LOW, an inclusive lower end
    localparam logic [15:0] BOOT_TOP      = 16'h0fff;
    localparam logic [15:0] LOW_RAM_TOP   = 16'h37ff;
    localparam logic [15:0] PRN_LOW       = 16'h37e8;
    localparam logic [15:0] PRN_HIGH      = 16'h37e9;
    localparam logic [15:0] KBD_TOP       = 16'h3bff;
    localparam logic [15:0] VID_TOP       = 16'h3fff;
    localparam logic [15:0] HI_RAM_TOP    = 16'hf3ff;
    localparam logic [15:0] HI_KBD_TOP    = 16'hf7ff;

    // what a decoded access reaches
    typedef enum logic [2:0] {
        REG_RAM_RW,
        REG_RAM_RO,
        REG_ROM_RD_RAM_WR,
        REG_BOOT_ROM,
        REG_PRINTER,
        REG_KEYBOARD,
        REG_VIDEO
    } mmd_region_e;

endpackage
`default_nettype wire

// >>> hdl/mmd_memory_ctrl.sv
// Functional notes
// - supports 64K or 128K of dram, chosen by a configuration input.
// - row and column address halves share lines, switched by mux select.
// - data transceiver enable comes from the map decode, its direction from the read line.
// - fast opcode fetch requests are cut short so precharge time is met.
// - the shortened request launches every ram access cycle.
// - fetch accesses finish without any wait state requested.
// - refresh cycles get a row strobe but no mux select or column strobe.
// - pre-row strobe drives bank 0 or bank 1 row strobe per bank select.
// - column strobe latches once asserted and holds to the cycle end.
// - column strobe is withheld on video memory accesses.
// - mode 0 boot on: rom, read-only ram, keyboard, video, upper ram.
// - mode 0 boot off: 0000-37ff is ram that ignores writes.
// - mode 0 decodes 37e8-37e9 as read-only printer status.
// - mode 1 boot on: rom reads, ram writes low; 1000-37ff read-write.
// - mode 1 boot off: 0000-37ff read-write ram, rest as mode 0.
// - mode 2 ignores boot; ram, keyboard f400, video f800-ffff.
// - mode 3 is all ram; boot enable ignored.
`timescale 1ns/1ns
`default_nettype none
module mmd_memory_ctrl
    import mmd_pkg::*;
#(
    parameter int RAM_128K_DEFAULT = 0
) (
    input  wire logic                          ref_clk_i,
    input  wire logic                          rst_i,
    // processor bus, asynchronous to this clock
    input  wire logic [mmd_pkg::ADDR_W-1:0]    cpu_addr_i,
    input  wire logic                          memory_request_i,
    input  wire logic                          opcode_fetch_cycle_i,
    input  wire logic                          refresh_cycle_i,
    input  wire logic                          cpu_read_i,
    input  wire logic                          cpu_write_i,
    input  wire logic                          ram_bank_i,
    // configuration bits from the port logic on this clock
    input  wire logic                          map_select_low_i,
    input  wire logic                          map_select_high_i,
    input  wire logic                          boot_rom_enable_i,
    input  wire logic                          fast_mode_i,
    input  wire logic                          ram_128k_i,
    // dram side
    output logic [mmd_pkg::DRAM_ADDR_W-1:0]    dram_addr_o,
    output logic                               row_strobe_bank0_n_o,
    output logic                               row_strobe_bank1_n_o,
    output logic                               address_mux_select_n_o,
    output logic                               column_strobe_n_o,
    output logic                               dram_write_n_o,
    output logic                               shortened_memory_request_o,
    // transceiver and selects
    output logic                               xcvr_enable_n_o,
    output logic                               xcvr_to_cpu_o,
    output logic                               boot_rom_sel_o,
    output logic                               printer_status_sel_o,
    output logic                               keyboard_sel_o,
    output logic                               video_access_o
);
    import mmd_pkg::*;

    // time to cycles, least times up, longest times down, never below one
    function automatic logic [CNT_W-1:0] cycles_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        if (c < 1) c = 1;
        return CNT_W'(c);
    endfunction

    function automatic logic [CNT_W-1:0] cycles_down(input int ns);
        int c;
        c = ns / CLK_PERIOD_NS;
        if (c < 1) c = 1;
        return CNT_W'(c);
    endfunction

    localparam logic [CNT_W-1:0] ROW_CYC   = cycles_up(ROW_TO_MUX_NS);
    localparam logic [CNT_W-1:0] COL_CYC   = cycles_up(MUX_TO_COL_NS);
    localparam logic [CNT_W-1:0] PRE_CYC   = cycles_up(PRECHARGE_NS);
    localparam logic [CNT_W-1:0] FETCH_CYC =
        cycles_down(FETCH_ACTIVE_NS - (PRECHARGE_NS - FETCH_REQ_NS));
    // never cut before the column strobe, or the fetch would read nothing
    localparam logic [CNT_W-1:0] MIN_CUT_CYC = CNT_W'(ROW_CYC + COL_CYC + 1);
    localparam logic [CNT_W-1:0] CUT_CYC     =
        (FETCH_CYC > MIN_CUT_CYC) ? FETCH_CYC : MIN_CUT_CYC;

    // map decode for one address in the current mode
    function automatic mmd_region_e decode(input logic [1:0] mode,
                                           input logic boot,
                                           input logic [15:0] a);
        mmd_region_e r;
        r = REG_RAM_RW;
        case (mode)
            MAP_MODE0: begin
                if (a >= PRN_LOW && a <= PRN_HIGH)
                    r = REG_PRINTER;
                else if (boot && a <= BOOT_TOP)
                    r = REG_BOOT_ROM;
                else if (a <= LOW_RAM_TOP)
                    r = REG_RAM_RO;
                else if (a <= KBD_TOP)
                    r = REG_KEYBOARD;
                else if (a <= VID_TOP)
                    r = REG_VIDEO;
            end
            MAP_MODE1: begin
                if (boot && a <= BOOT_TOP)
                    r = REG_ROM_RD_RAM_WR;
                else if (a <= LOW_RAM_TOP)
                    r = REG_RAM_RW;
                else if (a <= KBD_TOP)
                    r = REG_KEYBOARD;
                else if (a <= VID_TOP)
                    r = REG_VIDEO;
            end
            MAP_MODE2: begin
                if (a > HI_KBD_TOP)
                    r = REG_VIDEO;
                else if (a > HI_RAM_TOP)
                    r = REG_KEYBOARD;
            end
            MAP_MODE3: r = REG_RAM_RW;
            default:   r = REG_RAM_RW;
        endcase
        return r;
    endfunction

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ROW,
        ST_MUX,
        ST_HOLD,
        ST_PRE
    } mmd_state_e;

    // two-flop synchronisers for every processor pin
    localparam int SYNC_W = ADDR_W + 6;
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    always_ff @(posedge ref_clk_i) begin
        sync1_reg <= {cpu_addr_i, memory_request_i, opcode_fetch_cycle_i,
                      refresh_cycle_i, cpu_read_i, cpu_write_i, ram_bank_i};
        sync2_reg <= sync1_reg;
    end

    wire [ADDR_W-1:0] addr_s  = sync2_reg[SYNC_W-1:6];
    wire              memory_request_s  = sync2_reg[5];
    wire              fetch_s = sync2_reg[4];
    wire              refresh_cycle_s  = sync2_reg[3];
    wire              rd_s    = sync2_reg[2];
    wire              wr_s    = sync2_reg[1];
    wire              bank_s  = sync2_reg[0];

    // map mode from the two select bits
    wire [1:0]        map_mode = {map_select_high_i, map_select_low_i};
    wire mmd_region_e region   = decode(map_mode, boot_rom_enable_i,
                                        addr_s);

    // ram takes part unless the access is rom, keyboard, printer, video or a write to read-only ram
    wire ram_rd_ok = (region == REG_RAM_RW) || (region == REG_RAM_RO);
    wire ram_wr_ok = (region == REG_RAM_RW) ||
                     (region == REG_ROM_RD_RAM_WR);
    wire ram_hit   = (rd_s && ram_rd_ok) || (wr_s && ram_wr_ok);
    wire is_video  = (region == REG_VIDEO);

    // fetch request shortening: a fast fetch is cut after a fixed count
    // so the strobes rise early and precharge fits before the next fetch
    logic [CNT_W-1:0] fetch_cnt_reg;
    logic [CNT_W-1:0] fetch_cnt_next;
    wire fast_fetch = memory_request_s && fetch_s && fast_mode_i && !refresh_cycle_s;
    wire fetch_cut  = fast_fetch && (fetch_cnt_reg >= CUT_CYC);
    wire smreq      = memory_request_s && !fetch_cut;

    assign fetch_cnt_next = !fast_fetch ? '0 :
                            fetch_cut ? fetch_cnt_reg :
                            fetch_cnt_reg + 1'b1;

    // strobe sequencer, launched by the shortened request
    mmd_state_e       state_reg;
    mmd_state_e       state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             cas_latch_reg;
    logic             cas_latch_next;
    logic             refresh_cycle_cyc_reg;
    logic             bank_reg;
    logic             ram_128k_reg;
    wire              cnt_done = (cnt_reg <= 1'b1);

    always_comb begin
        state_next     = state_reg;
        cnt_next       = cnt_reg;
        cas_latch_next = cas_latch_reg;
        case (state_reg)
            ST_IDLE: begin
                if (smreq) begin
                    state_next = ST_ROW;
                    cnt_next   = ROW_CYC;
                end
            end
            ST_ROW: begin
                if (!smreq) begin
                    state_next = ST_PRE;
                    cnt_next   = PRE_CYC;
                end else if (cnt_done) begin
                    // refresh keeps the row strobe only
                    state_next = refresh_cycle_cyc_reg ? ST_HOLD : ST_MUX;
                    cnt_next   = COL_CYC;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            ST_MUX: begin
                if (!smreq) begin
                    state_next = ST_PRE;
                    cnt_next   = PRE_CYC;
                end else if (cnt_done) begin
                    state_next     = ST_HOLD;
                    cas_latch_next = ram_hit && !is_video;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            ST_HOLD: begin
                // held until the request ends, no wait is ever asked for
                if (!smreq) begin
                    state_next     = ST_PRE;
                    cnt_next       = PRE_CYC;
                    cas_latch_next = 1'b0;
                end
            end
            ST_PRE: begin
                cas_latch_next = 1'b0;
                if (cnt_done)
                    state_next = ST_IDLE;
                else
                    cnt_next = cnt_reg - 1'b1;
            end
            default: begin
                state_next     = ST_IDLE;
                cas_latch_next = 1'b0;
            end
        endcase
    end

    // next values of the strobes; outputs are all registered
    wire pre_row_next = (state_next == ST_ROW) || (state_next == ST_MUX) ||
                        (state_next == ST_HOLD);
    wire start_cyc    = (state_reg == ST_IDLE) && (state_next == ST_ROW);
    wire bank_next    = start_cyc ? (bank_s && ram_128k_reg) : bank_reg;
    wire refresh_cycle_next    = start_cyc ? refresh_cycle_s : refresh_cycle_cyc_reg;
    wire mux_next     = !refresh_cycle_next &&
                        ((state_next == ST_MUX) || (state_next == ST_HOLD));
    wire col_sel      = mux_next;
    wire [DRAM_ADDR_W-1:0] addr_next =
        col_sel ? addr_s[ADDR_W-1:DRAM_ADDR_W]
                : addr_s[DRAM_ADDR_W-1:0];
    wire active_next  = pre_row_next && !refresh_cycle_next;
    wire xcvr_next    = active_next && ram_hit;

    // memory size loads RAM_128K_DEFAULT in reset, then is registered from its input every cycle; a 64K build has no bank 1
    always_ff @(posedge ref_clk_i) begin
        if (rst_i)
            ram_128k_reg <= RAM_128K_DEFAULT != 0;
        else
            ram_128k_reg <= ram_128k_i;
    end

    // sequencer state
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_reg     <= ST_IDLE;
            cnt_reg       <= '0;
            cas_latch_reg <= 1'b0;
            fetch_cnt_reg <= '0;
            refresh_cycle_cyc_reg  <= 1'b0;
            bank_reg      <= 1'b0;
        end else begin
            state_reg     <= state_next;
            cnt_reg       <= cnt_next;
            cas_latch_reg <= cas_latch_next;
            fetch_cnt_reg <= fetch_cnt_next;
            refresh_cycle_cyc_reg  <= refresh_cycle_next;
            bank_reg      <= bank_next;
        end
    end

    // dram strobes and address lines
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            row_strobe_bank0_n_o       <= 1'b1;
            row_strobe_bank1_n_o       <= 1'b1;
            address_mux_select_n_o     <= 1'b1;
            column_strobe_n_o          <= 1'b1;
            dram_write_n_o             <= 1'b1;
            dram_addr_o                <= '0;
            shortened_memory_request_o <= 1'b0;
        end else begin
            row_strobe_bank0_n_o       <= !(pre_row_next && !bank_next);
            row_strobe_bank1_n_o       <= !(pre_row_next && bank_next);
            address_mux_select_n_o     <= !mux_next;
            column_strobe_n_o          <= !cas_latch_next;
            dram_write_n_o             <= !(active_next && wr_s &&
                                            ram_wr_ok);
            dram_addr_o                <= addr_next;
            shortened_memory_request_o <= smreq;
        end
    end

    // transceiver and device selects follow the decode
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            xcvr_enable_n_o      <= 1'b1;
            xcvr_to_cpu_o        <= 1'b0;
            boot_rom_sel_o       <= 1'b0;
            printer_status_sel_o <= 1'b0;
            keyboard_sel_o       <= 1'b0;
            video_access_o       <= 1'b0;
        end else begin
            xcvr_enable_n_o      <= !xcvr_next;
            xcvr_to_cpu_o        <= rd_s;
            boot_rom_sel_o       <= memory_request_s && rd_s &&
                                    ((region == REG_BOOT_ROM) ||
                                     (region == REG_ROM_RD_RAM_WR));
            printer_status_sel_o <= memory_request_s && rd_s &&
                                    (region == REG_PRINTER);
            keyboard_sel_o       <= memory_request_s && (region == REG_KEYBOARD);
            video_access_o       <= memory_request_s && !refresh_cycle_s && is_video;
        end
    end

endmodule // mmd_memory_ctrl
`default_nettype wire

// >>> tb/mmd_memory_ctrl_props.sv
`timescale 1ns/1ns
`default_nettype none
module mmd_memory_ctrl_props (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic map_select_low_i,
    input wire logic map_select_high_i,
    input wire logic ram_128k_i,
    input wire logic row_strobe_bank0_n_o,
    input wire logic row_strobe_bank1_n_o,
    input wire logic address_mux_select_n_o,
    input wire logic column_strobe_n_o,
    input wire logic dram_write_n_o,
    input wire logic shortened_memory_request_o,
    input wire logic xcvr_enable_n_o,
    input wire logic xcvr_to_cpu_o,
    input wire logic boot_rom_sel_o,
    input wire logic printer_status_sel_o,
    input wire logic keyboard_sel_o,
    input wire logic video_access_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // helpers: no row strobe down, a non-ram target, all-ram mode
    wire logic rows_high = row_strobe_bank0_n_o & row_strobe_bank1_n_o;
    wire logic non_ram = boot_rom_sel_o | printer_status_sel_o
                       | keyboard_sel_o | video_access_o;
    wire logic mode3 = map_select_high_i & map_select_low_i;
    wire logic small_ram = !ram_128k_i;

    a_bank_exclusive: assert property (
        row_strobe_bank0_n_o || row_strobe_bank1_n_o)
        else $error("both row strobes low");
    a_mux_needs_row: assert property (
        !address_mux_select_n_o |-> !rows_high)
        else $error("mux select without row strobe");
    a_col_after_mux: assert property (
        $fell(column_strobe_n_o) |-> !$past(address_mux_select_n_o))
        else $error("column strobe before mux select");
    a_release_together: assert property (
        $rose(rows_high) |-> address_mux_select_n_o && column_strobe_n_o)
        else $error("column strobe outlived the cycle");
    a_precharge_gap: assert property (
        $rose(rows_high) |=> rows_high)
        else $error("precharge shorter than two cycles");
    a_non_ram_quiet: assert property (
        non_ram |-> column_strobe_n_o && xcvr_enable_n_o && dram_write_n_o)
        else $error("dram touched on non-ram access");
    a_sel_onehot: assert property (
        $onehot0({boot_rom_sel_o, printer_status_sel_o,
                  keyboard_sel_o, video_access_o}))
        else $error("two targets selected");
    a_write_path: assert property (
        !dram_write_n_o |-> !xcvr_enable_n_o && !xcvr_to_cpu_o)
        else $error("write without transceiver toward ram");
    a_mode3_ram: assert property (
        mode3 && $past(mode3, 3) |-> !non_ram)
        else $error("non-ram target in all-ram mode");
    a_small_ram_bank0: assert property (
        small_ram && $past(small_ram, 8) |-> row_strobe_bank1_n_o)
        else $error("bank 1 strobed in 64k build");
    a_launch_by_request: assert property (
        $fell(rows_high) |-> shortened_memory_request_o)
        else $error("row strobe without shortened request");
    a_cut_ends_rows: assert property (
        $rose(rows_high) |-> !shortened_memory_request_o)
        else $error("row strobe released while request stands");

    c_bank1: cover property (!row_strobe_bank1_n_o);
    c_video: cover property (video_access_o);
    c_column: cover property ($fell(column_strobe_n_o));
endmodule // mmd_memory_ctrl_props

bind mmd_memory_ctrl mmd_memory_ctrl_props mmd_memory_ctrl_props_inst (
    .ref_clk_i, .rst_i, .map_select_low_i, .map_select_high_i, .ram_128k_i,
    .row_strobe_bank0_n_o, .row_strobe_bank1_n_o, .address_mux_select_n_o,
    .column_strobe_n_o, .dram_write_n_o, .xcvr_enable_n_o, .xcvr_to_cpu_o,
    .boot_rom_sel_o, .printer_status_sel_o, .keyboard_sel_o,
    .video_access_o, .shortened_memory_request_o);
`default_nettype wire

// >>> tb/mmd_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module mmd_cpu_model (
    input  wire logic        ref_clk_i,
    input  wire logic [18:0] obs_i,
    output logic      [15:0] addr_o,
    output logic             memory_request_o,
    output logic             fetch_o,
    output logic             refresh_cycle_o,
    output logic             rd_o,
    output logic             wr_o,
    output logic             bank_o
);
    // col, write, xcvr, read, boot, printer, keyboard, video seen
    logic [7:0] seen;
    logic [1:0] rows_seen;
    logic       mux_seen;
    logic [7:0] row_byte;
    logic [7:0] col_byte;
    int         row_cycles;

    initial begin
        {addr_o, memory_request_o, fetch_o, refresh_cycle_o, rd_o, wr_o, bank_o} = '0;
    end

    // one bus cycle; pin held for hold edges, then released with the
    // address inverted so a stale value cannot pass for a good one
    task automatic run(input logic [15:0] a, input logic w, f, r, b,
                       input int hold);
        int i;
        {seen, rows_seen, mux_seen, row_cycles} = '0;
        @(posedge ref_clk_i);
        {addr_o, memory_request_o, fetch_o, refresh_cycle_o, bank_o} <= {a, 1'b1, f, r, b};
        rd_o <= !w && !r;
        wr_o <= w;
        for (i = 0; i < hold + 6; i++) begin
            @(posedge ref_clk_i);
            if (i == hold - 1) begin
                {memory_request_o, fetch_o, refresh_cycle_o, rd_o, wr_o} <= '0;
                addr_o <= ~a;
            end
            #1;
            if (!(obs_i[10] && obs_i[9])) begin
                if (rows_seen == 2'h0) row_byte = obs_i[18:11];
                rows_seen = rows_seen | ~obs_i[10:9];
                row_cycles++;
            end
            if (!obs_i[8] && !mux_seen) col_byte = obs_i[18:11];
            mux_seen = mux_seen | !obs_i[8];
            seen = seen | {~obs_i[7:5], ~obs_i[5] & obs_i[4], obs_i[3:0]};
        end
    endtask
endmodule // mmd_cpu_model
`default_nettype wire

// >>> tb/mmd_memory_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
    num_errors++; \
    $display("wrong value t=%0t got=%h exp=%h", $time, got, exp); end end
module mmd_memory_ctrl_tb;
    import mmd_pkg::*;
    logic       ref_clk_i;
    logic       rst_i;
    logic [1:0] map_sel;
    logic       boot_en, fast, r128;
    wire logic [ADDR_W-1:0] cpu_addr;
    wire logic [DRAM_ADDR_W-1:0] dram_addr;
    wire logic memory_request, fetch, refresh_cycle, rd, wr, bank, smreq;
    wire logic row0_n, row1_n, mux_n, col_n, wr_n, xen_n, to_cpu;
    wire logic boot_sel, prn_sel, kbd_sel, vid_sel;
    int num_errors = 0;
    int checks_done = 0;

    mmd_memory_ctrl #(.RAM_128K_DEFAULT(0)) mmd_memory_ctrl_inst (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cpu_addr_i(cpu_addr),
        .memory_request_i(memory_request), .opcode_fetch_cycle_i(fetch),
        .refresh_cycle_i(refresh_cycle), .cpu_read_i(rd), .cpu_write_i(wr),
        .ram_bank_i(bank), .map_select_low_i(map_sel[0]),
        .map_select_high_i(map_sel[1]), .boot_rom_enable_i(boot_en),
        .fast_mode_i(fast), .ram_128k_i(r128), .dram_addr_o(dram_addr),
        .row_strobe_bank0_n_o(row0_n), .row_strobe_bank1_n_o(row1_n),
        .address_mux_select_n_o(mux_n), .column_strobe_n_o(col_n),
        .dram_write_n_o(wr_n), .shortened_memory_request_o(smreq),
        .xcvr_enable_n_o(xen_n), .xcvr_to_cpu_o(to_cpu),
        .boot_rom_sel_o(boot_sel), .printer_status_sel_o(prn_sel),
        .keyboard_sel_o(kbd_sel), .video_access_o(vid_sel));

    mmd_cpu_model mmd_cpu_model_inst (
        .ref_clk_i(ref_clk_i), .addr_o(cpu_addr), .memory_request_o(memory_request),
        .fetch_o(fetch), .refresh_cycle_o(refresh_cycle), .rd_o(rd), .wr_o(wr), .bank_o(bank),
        .obs_i({dram_addr, row0_n, row1_n, mux_n, col_n, wr_n, xen_n,
                to_cpu, boot_sel, prn_sel, kbd_sel, vid_sel}));

    // 10 MHz processor clock
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    // configuration change, then one read or write with its flags judged
    task automatic map_case(input logic [1:0] m, input logic b, w,
                            input logic [15:0] a, input logic [7:0] exp);
        @(posedge ref_clk_i);
        map_sel <= m;
        boot_en <= b;
        mmd_cpu_model_inst.run(a, w, 1'b0, 1'b0, 1'b0, 8);
        `CHK(mmd_cpu_model_inst.seen, exp)
    endtask

    // refresh, bank steering and the address halves, all in mode 3
    task automatic dram_cases();
        logic [4:0] got;
        mmd_cpu_model_inst.run(16'h1234, 1'b0, 1'b0, 1'b1, 1'b0, 8);
        got = {|mmd_cpu_model_inst.rows_seen, mmd_cpu_model_inst.mux_seen,
               mmd_cpu_model_inst.seen[7:5]};
        `CHK(got, 5'h10)
        mmd_cpu_model_inst.run(16'hab35, 1'b0, 1'b0, 1'b0, 1'b0, 8);
        `CHK(mmd_cpu_model_inst.row_byte, 8'h35)
        `CHK(mmd_cpu_model_inst.col_byte, 8'hab)
        @(posedge ref_clk_i);
        r128 <= 1'b1;
        mmd_cpu_model_inst.run(16'h8000, 1'b0, 1'b0, 1'b0, 1'b1, 8);
        `CHK(mmd_cpu_model_inst.rows_seen, 2'h1)
        @(posedge ref_clk_i);
        r128 <= 1'b0;
        mmd_cpu_model_inst.run(16'h8000, 1'b0, 1'b0, 1'b0, 1'b1, 8);
        `CHK(mmd_cpu_model_inst.rows_seen, 2'h2)
    endtask

    // a long fetch: cut short only in the fast mode
    task automatic fetch_case(input logic f, input logic exp_short);
        @(posedge ref_clk_i);
        fast <= f;
        mmd_cpu_model_inst.run(16'h5000, 1'b0, 1'b1, 1'b0, 1'b0, 12);
        `CHK(mmd_cpu_model_inst.row_cycles < 5, exp_short)
        `CHK(mmd_cpu_model_inst.seen[7], 1'b1)
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        rst_i = 1'b1;
        {map_sel, boot_en, fast, r128} = 5'h04;
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        #1;
        `CHK({row0_n, row1_n, mux_n, col_n}, 4'hf)
        `CHK({wr_n, xen_n, dram_addr}, 10'h300)
        map_case(2'h0, 1'h1, 1'h0, 16'h0100, 8'h08);
        map_case(2'h0, 1'h1, 1'h1, 16'h1000, 8'h00);
        map_case(2'h0, 1'h1, 1'h0, 16'h1000, 8'hb0);
        map_case(2'h0, 1'h1, 1'h0, 16'h37e8, 8'h04);
        map_case(2'h0, 1'h1, 1'h0, 16'h3900, 8'h02);
        map_case(2'h0, 1'h1, 1'h0, 16'h3c10, 8'h01);
        map_case(2'h0, 1'h1, 1'h1, 16'h4000, 8'he0);
        map_case(2'h0, 1'h0, 1'h1, 16'h0200, 8'h00);
        map_case(2'h0, 1'h0, 1'h0, 16'h0200, 8'hb0);
        map_case(2'h1, 1'h1, 1'h0, 16'h0100, 8'h08);
        map_case(2'h1, 1'h1, 1'h1, 16'h0100, 8'he0);
        map_case(2'h1, 1'h1, 1'h0, 16'h37e8, 8'hb0);
        map_case(2'h1, 1'h0, 1'h1, 16'h0100, 8'he0);
        map_case(2'h1, 1'h0, 1'h0, 16'h3c00, 8'h01);
        map_case(2'h2, 1'h1, 1'h0, 16'h0100, 8'hb0);
        map_case(2'h2, 1'h1, 1'h1, 16'hf3ff, 8'he0);
        map_case(2'h2, 1'h1, 1'h0, 16'hf400, 8'h02);
        map_case(2'h2, 1'h1, 1'h0, 16'hf800, 8'h01);
        map_case(2'h3, 1'h1, 1'h0, 16'h0100, 8'hb0);
        map_case(2'h3, 1'h1, 1'h1, 16'hffff, 8'he0);
        dram_cases();
        fetch_case(1'b1, 1'b1);
        fetch_case(1'b0, 1'b0);
        stop_test();
    end

    // hang guard, far above the few hundred cycles the run needs
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        num_errors++;
        stop_test();
    end
endmodule // mmd_memory_ctrl_tb
`default_nettype wire
